// ==== inc/bacp_exc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface bacp_exc_if;
    logic       outside;
    logic [1:0] rate;
    logic       pin_a_in;
    logic       pin_a;
    logic       pin_a_oe;
    logic       pin_b;
    logic       demod_phase;
    modport ctl (output outside, rate, pin_a_in,
                 input pin_a, pin_a_oe, pin_b, demod_phase);
    modport gen (input outside, rate, pin_a_in,
                 output pin_a, pin_a_oe, pin_b, demod_phase);
endinterface
`default_nettype wire

// ==== inc/bacp_pkg.sv ====
package bacp_pkg;
    localparam int CMD_W        = 8;
    localparam int WORD_W       = 24;
    localparam int CNT_W        = 5;
    localparam logic [4:0] CMD_LAST  = 5'h07;
    localparam logic [4:0] WORD_LAST = 5'h17;
    localparam int CMD_MARK     = 7;
    localparam int SEL_HI       = 6;
    localparam int SEL_LO       = 4;
    localparam int RW_BIT       = 3;
    localparam logic [2:0] CMD_LOW_ZERO = 3'h0;
    localparam logic [2:0] SEL_RESULT   = 3'h0;
    localparam logic [2:0] SEL_SETUP    = 3'h1;
    localparam logic [2:0] SEL_GAIN     = 3'h2;
    localparam logic [2:0] SEL_TRIM     = 3'h3;
    localparam logic [2:0] SEL_RATIO    = 3'h4;
    localparam logic [2:0] SEL_SIGOFS   = 3'h5;
    localparam logic [2:0] SEL_REFOFS   = 3'h6;
    localparam logic [2:0] SEL_BAD      = 3'h7;
    localparam int TRIM_HI      = 23;
    localparam int TRIM_LO      = 20;
    localparam int F_OUTSIDE    = 19;
    localparam int F_RATE_HI    = 18;
    localparam int F_RATE_LO    = 17;
    localparam int F_GAIN_HI    = 15;
    localparam int F_GAIN_LO    = 14;
    localparam int F_POLARITY   = 13;
    localparam int F_SLEEP      = 11;
    localparam int F_RUNCAL     = 10;
    localparam int F_CALT_HI    = 7;
    localparam int F_CALT_LO    = 4;
    localparam int F_FILTCLR    = 0;
    localparam logic [23:0] SETUP_RST = 24'h000000;
    localparam logic [23:0] GAIN_RST  = 24'h800000;
    localparam logic [23:0] ZERO_RST  = 24'h000000;
    localparam logic [1:0] RATE_DC  = 2'h0;
    localparam logic [1:0] RATE_8K  = 2'h1;
    localparam logic [1:0] RATE_16K = 2'h2;
    localparam logic [1:0] RATE_4K  = 2'h3;
    localparam int DIV_W = 14;
    localparam logic [13:0] HALF_4K  = 14'h07ff;
    localparam logic [13:0] HALF_8K  = 14'h0fff;
    localparam logic [13:0] HALF_16K = 14'h1fff;
    localparam int CAL_SHORT = 573440;
    localparam int CAL_LONG  = 2211840;
    localparam logic [3:0] CALT_NONE  = 4'h0;
    localparam logic [3:0] CALT_RATIO = 4'h2;
    localparam int CAL_W = 22;
    typedef enum logic [2:0] {
        BACP_CMD  = 3'b000,
        BACP_WR   = 3'b001,
        BACP_FET  = 3'b011,
        BACP_RD   = 3'b010,
        BACP_CAL  = 3'b110
    } bacp_state_t;
endpackage

// ==== test/bacp_core_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module bacp_core_checker #(
    parameter int CAL_SHORT_CYC = 20,
    parameter int CAL_LONG_CYC  = 40
) (
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_cs_n,
    input wire logic        o_sdo_oe,
    input wire logic        o_data_ready_n,
    input wire logic        o_excitation_pin_a,
    input wire logic        o_excitation_pin_a_oe,
    input wire logic        o_excitation_pin_b,
    input wire logic [3:0]  o_pga_gain,
    input wire logic        o_unipolar,
    input wire logic        o_sleep,
    input wire logic        o_filter_clear,
    input wire logic [3:0]  o_cal_type,
    input wire logic        o_cal_busy,
    input wire logic        o_cal_start,
    input wire logic [23:0] o_setup_word
);
    wire  [23:0] w = o_setup_word;
    logic [21:0] cnt_r;
    logic [21:0] cnt_nxt;
    logic [3:0]  gain_x;
    logic        len_ok;
    logic        mode_ok;
    int          len_x;
    always_comb begin
        cnt_nxt = o_cal_busy ? cnt_r + 22'h1 : 22'h0;
        gain_x = 4'h1 << {w[14], w[15]};
        len_x = (o_cal_type == 4'h2) ? CAL_LONG_CYC : CAL_SHORT_CYC;
        len_ok = (int'(cnt_r) + 1 >= len_x) && (int'(cnt_r) <= len_x + 1);
        mode_ok = o_unipolar == w[13] && o_sleep == w[11]
            && o_filter_clear == w[0] && o_cal_type == w[7:4];
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cnt_r <= 22'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_cal_begin;
        $rose(o_cal_busy) ##0 o_cal_start;
    endsequence
    sequence s_cal_end;
        $fell(o_cal_busy);
    endsequence
    // Word unchanged for two cycles, so decoded outputs have caught up
    sequence s_settled;
        w == $past(w, 2) && $stable(w);
    endsequence
    chk_oe_free: assert property (i_cs_n |-> !o_sdo_oe)
        else $error("serial output driven while deselected");
    chk_busy_ready: assert property (o_cal_busy |-> o_data_ready_n)
        else $error("ready low during calibration");
    chk_cal_cause: assert property (s_cal_begin |-> w[10])
        else $error("calibration started without run bit");
    chk_start_once: assert property (o_cal_start |=> !o_cal_start)
        else $error("calibration start longer than one cycle");
    chk_cal_len: assert property (s_cal_end |-> len_ok)
        else $error("calibration length wrong");
    chk_ready_end: assert property (s_cal_end |-> ##[0:1] !o_data_ready_n)
        else $error("ready not low after calibration");
    chk_gain_map: assert property (s_settled |-> o_pga_gain == gain_x)
        else $error("gain decode wrong");
    chk_mode_bits: assert property (s_settled |-> mode_ok)
        else $error("mode outputs differ from setup word");
    chk_pin_static: assert property (s_settled ##0 w[19:17] == 3'h0 |->
        !o_excitation_pin_a && o_excitation_pin_b && o_excitation_pin_a_oe)
        else $error("static excitation levels wrong");
    chk_pin_input: assert property (s_settled ##0 w[19] |->
        !o_excitation_pin_a_oe)
        else $error("pin a driven under outside drive");
endmodule
`default_nettype wire

// ==== test/bacp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module bacp_host (
    input  wire logic i_ref_clk,
    input  wire logic i_sdo,
    input  wire logic i_data_ready_n,
    output var logic  o_sclk,
    output var logic  o_cs_n,
    output var logic  o_sdi
);
    logic idle_r = 1'b1;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end
    // Data line is not held while deselected
    always @(posedge i_ref_clk) begin
        if (idle_r) begin
            o_sdi <= ~o_sdi;
        end
    end
    task automatic put_bit(input logic b, output logic s);
        @(posedge i_ref_clk);
        o_sdi <= b;
        repeat (3) @(posedge i_ref_clk);
        s = i_sdo;
        o_sclk <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        o_sclk <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd,
                         input int nbits, output logic [23:0] rd,
                         output logic late);
        logic s;
        int   n;
        rd = 24'h0;
        late = 1'b0;
        n = 0;
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        idle_r <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            put_bit(cmd[i], s);
        end
        while (cmd[3] && i_data_ready_n !== 1'b0 && n < 40) begin
            @(posedge i_ref_clk);
            n++;
        end
        late = (n >= 40);
        for (int i = 0; i < nbits && !late; i++) begin
            put_bit(wd[23 - i], s);
            rd = {rd[22:0], s};
        end
        repeat (3) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        idle_r <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== test/bridge_adc_command_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module bridge_adc_command_port_tb_top;
    logic        i_ref_clk, i_sys_rst, i_sclk, i_cs_n, i_sdi, i_result_valid;
    logic        i_excitation_pin_a, o_sdo, o_sdo_oe, o_data_ready_n, late;
    logic        o_excitation_pin_a, o_excitation_pin_a_oe, o_excitation_pin_b;
    logic        o_demod_phase, o_trim_subtract, o_unipolar, o_sleep;
    logic        o_cal_busy, o_cal_start, o_filter_clear;
    logic [3:0]  o_trim_level, o_pga_gain, o_cal_type, t;
    logic [23:0] i_result, o_setup_word, wd, rd, ex;
    logic [7:0]  bad [3] = '{8'h18, 8'h99, 8'hf8};
    int          failures = 0, total_checks = 0, seed = 39958, starts = 0, n;
    bacp_core #(.CAL_SHORT_CYC(20), .CAL_LONG_CYC(40)) i_bacp_core (
        .i_ref_clk, .i_sys_rst, .i_ce(1'b1), .i_sclk, .i_cs_n, .i_sdi, .o_sdo,
        .o_sdo_oe, .o_data_ready_n, .i_result, .i_result_valid,
        .i_excitation_pin_a, .o_excitation_pin_a, .o_excitation_pin_a_oe,
        .o_excitation_pin_b, .o_demod_phase, .o_trim_level, .o_trim_subtract,
        .o_pga_gain, .o_unipolar, .o_sleep, .o_cal_type, .o_cal_busy,
        .o_cal_start, .o_filter_clear, .o_setup_word
    );
    bacp_host u_host (
        .i_ref_clk, .i_sdo(o_sdo), .i_data_ready_n(o_data_ready_n),
        .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi)
    );
    function automatic logic [3:0] gain_exp(input logic [1:0] c);
        return (c == 2'h0) ? 4'h1 : (c == 2'h2) ? 4'h2 : (c == 2'h1) ? 4'h4 : 4'h8;
    endfunction
    function automatic int half_exp(input logic [1:0] r);
        return (r == 2'h3) ? 2048 : (r == 2'h1) ? 4096 : 8192;
    endfunction
    task automatic cmp(input string what, input logic [23:0] e,
                       input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic put(input logic [7:0] c, input logic [23:0] d);
        u_host.frame(c, d, 24, rd, late);
    endtask
    // Bounded wait for a level change on pin a, twice: sync, then measure
    task automatic half_period(input int lim);
        logic p;
        for (int k = 0; k < 2; k++) begin
            p = o_excitation_pin_a;
            n = 0;
            while (o_excitation_pin_a === p && n < lim) begin
                @(posedge i_ref_clk);
                n++;
            end
        end
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        i_excitation_pin_a <= 1'($random(seed));
        if (o_cal_start === 1'b1) begin
            starts++;
        end
    end
    initial begin
        i_sys_rst = 1'b1;
        i_result = 24'h0;
        i_result_valid = 1'b0;
        i_excitation_pin_a = 1'b0;
        repeat (16) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_ref_clk);
        cmp("setup reset", 24'h0, o_setup_word);
        cmp("ready reset", 24'h1, o_data_ready_n);
        cmp("trim reset", 24'h1, o_trim_level);
        for (int i = 0; i < 6; i++) begin
            wd = 24'($random(seed)) & 24'hfee8f1;
            wd[15:14] = (i < 4) ? i[1:0] : wd[15:14];
            ex = {4'h0, wd[19:0]};
            put(8'h90, wd);
            cmp("setup word", ex, o_setup_word);
            cmp("gain", gain_exp(wd[15:14]), o_pga_gain);
            cmp("cal type", wd[7:4], o_cal_type);
            u_host.frame(8'h98, 24'h0, 24, rd, late);
            cmp("setup read", ex, rd);
        end
        t = 4'($random(seed));
        put(8'hb0, {20'h0, t});
        put(8'h90, 24'hf00000);
        cmp("setup mirror", {t, 20'h0}, o_setup_word);
        cmp("trim level", {1'b0, t[2:0]} + 4'h1, o_trim_level);
        cmp("trim sign", t[3], o_trim_subtract);
        foreach (bad[k]) begin
            u_host.frame(bad[k], 24'h0, 24, rd, late);
            cmp("bad command", 24'h1, late);
        end
        cmp("setup kept", {t, 20'h0}, o_setup_word);
        i_result <= 24'($random(seed));
        i_result_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_result_valid <= 1'b0;
        u_host.frame(8'h88, 24'h0, 8, rd, late);
        cmp("result head", {16'h0, i_result[23:16]}, rd);
        cmp("port freed", 24'h0, o_sdo_oe);
        cmp("ready after abort", 24'h1, o_data_ready_n);
        for (int r = 1; r < 4; r++) begin
            put(8'h90, {5'h0, r[1:0], 17'h0});
            half_period(9000);
            cmp("half period", half_exp(r[1:0]), n);
        end
        put(8'h90, 24'h080000);
        cmp("pin a input", 24'h0, o_excitation_pin_a_oe);
        @(posedge i_ref_clk);
        cmp("demod phase", i_excitation_pin_a, o_demod_phase);
        cmp("pin b", {23'h0, ~i_excitation_pin_a}, o_excitation_pin_b);
        for (int k = 0; k < 5; k++) begin
            if (k < 4) begin
                put(8'h90, {13'h0, 1'b1, 2'h0, 4'h8 >> k, 4'h0});
            end else begin
                put(8'ha0, 24'h800000);
            end
            n = 0;
            while (o_data_ready_n !== 1'b0 && n < 100) begin
                @(posedge i_ref_clk);
                n++;
            end
            cmp("ready after cal", 24'h0, o_data_ready_n);
            cmp("cal count", k + 1, starts);
        end
        put(8'h90, 24'h0);
        cmp("no rerun", 24'h5, starts);
        stop_test();
    end
endmodule
bind bacp_core bacp_core_checker #(
    .CAL_SHORT_CYC(CAL_SHORT_CYC), .CAL_LONG_CYC(CAL_LONG_CYC)
) i_bacp_core_checker (
    .i_ref_clk, .i_sys_rst, .i_cs_n, .o_sdo_oe, .o_data_ready_n,
    .o_excitation_pin_a, .o_excitation_pin_a_oe, .o_excitation_pin_b,
    .o_pga_gain, .o_unipolar, .o_sleep, .o_filter_clear, .o_cal_type,
    .o_cal_busy, .o_cal_start, .o_setup_word
);
`default_nettype wire

// ==== verilog/bacp_core.sv ====
// Function
// - Register select picks result, setup, gain, trim or three offsets.
// - Read/write bit zero writes the selected register (result excepted), one reads it.
// - After reset the port waits in command mode for eight bits.
// - A valid command, except a result write, enters data mode for exactly 24 clocks.
// - Write data may follow the command byte with no pause.
// - On reads host waits for data_ready_n low before clocking data.
// - Chip select inactive ends host control and frees the port.
// - Each new setup word is decoded and acted upon.
// - Bits 23..20 mirror the trim register; setup writes leave them.
// - Trim magnitude steps 25 percent per code, 000 is 25 percent.
// - Outside drive zero drives both pins; one makes pin a input.
// - Rate 00 static, 01/10/11 toggle at clock over 8192/16384/4096.
// - Gain code 00=1, 10=2, 01=4, 11=8 after fixed gain 25.
// - Polarity zero bipolar, one unipolar; sleep one puts device asleep.
// - Run calibration starts chosen calibration; host clears it after.
// - Calibration type codes 0000 none, 1000, 0100, 0010, 0001.
// - Filter clear bit zero one resets the digital filter.
// - Setup word acts, calibration starts, at 24th data clock fall.
// - With run calibration set every full write reruns calibration; here only when calibration type is not 0000.
// - data_ready_n stays high during calibration and falls at its end.
`timescale 1ns/1ps
`default_nettype none
module bacp_core #(
    parameter int CAL_SHORT_CYC = bacp_pkg::CAL_SHORT,
    parameter int CAL_LONG_CYC  = bacp_pkg::CAL_LONG
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_sdi,
    output logic             o_sdo,
    output logic             o_sdo_oe,
    output logic             o_data_ready_n,
    input  wire logic [23:0] i_result,
    input  wire logic        i_result_valid,
    input  wire logic        i_excitation_pin_a,
    output logic             o_excitation_pin_a,
    output logic             o_excitation_pin_a_oe,
    output logic             o_excitation_pin_b,
    output logic             o_demod_phase,
    output logic [3:0]       o_trim_level,
    output logic             o_trim_subtract,
    output logic [3:0]       o_pga_gain,
    output logic             o_unipolar,
    output logic             o_sleep,
    output logic [3:0]       o_cal_type,
    output logic             o_cal_busy,
    output logic             o_cal_start,
    output logic             o_filter_clear,
    output logic [23:0]      o_setup_word
);
    localparam int NREG = 7;

    bacp_pkg::bacp_state_t st_r, st_nxt;
    logic [bacp_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [bacp_pkg::WORD_W-1:0] shin_r, shin_nxt;
    logic [bacp_pkg::WORD_W-1:0] shout_r, shout_nxt;
    logic [2:0]                  sel_r, sel_nxt;
    logic                        sdo_r, sdo_nxt;
    logic                        data_ready_n_n_r, data_ready_n_n_nxt;
    logic                        sclk_d_r;
    logic                        start_r, start_nxt;
    logic [bacp_pkg::CAL_W-1:0]  calcnt_r, calcnt_nxt;
    logic [bacp_pkg::WORD_W-1:0] regs_r [NREG];
    logic [bacp_pkg::WORD_W-1:0] regs_nxt [NREG];
    logic                        rise, fall;
    logic [bacp_pkg::CMD_W-1:0]  cmd;
    logic                        wr_done;

    bacp_exc_if exc ();
    bacp_exc_gen u_exc (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .exc       (exc)
    );

    function automatic logic cmd_ok(input logic [7:0] c);
        cmd_ok = c[bacp_pkg::CMD_MARK]
              && c[2:0] == bacp_pkg::CMD_LOW_ZERO
              && c[bacp_pkg::SEL_HI:bacp_pkg::SEL_LO] != bacp_pkg::SEL_BAD;
    endfunction

    function automatic logic [bacp_pkg::CAL_W-1:0] cal_len(
        input logic [3:0] t);
        if (t == bacp_pkg::CALT_RATIO)
            cal_len = bacp_pkg::CAL_W'(CAL_LONG_CYC - 1);
        else
            cal_len = bacp_pkg::CAL_W'(CAL_SHORT_CYC - 1);
    endfunction

    assign rise = i_sclk & ~sclk_d_r & ~i_cs_n;
    assign fall = ~i_sclk & sclk_d_r & ~i_cs_n;
    // Command is decoded on its own eighth fall, so that fall is not data
    assign cmd  = shin_r[bacp_pkg::CMD_W-1:0];
    logic [23:0] setup;
    assign setup = regs_r[bacp_pkg::SEL_SETUP];
    assign wr_done = (st_r == bacp_pkg::BACP_WR) && fall
                   && cnt_r == bacp_pkg::WORD_LAST;

    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        shin_nxt   = shin_r;
        shout_nxt  = shout_r;
        sel_nxt    = sel_r;
        sdo_nxt    = sdo_r;
        data_ready_n_n_nxt = data_ready_n_n_r;
        start_nxt  = 1'b0;
        calcnt_nxt = calcnt_r;
        for (int i = 0; i < NREG; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        regs_nxt[bacp_pkg::SEL_RESULT] = i_result_valid ? i_result
                                         : regs_r[bacp_pkg::SEL_RESULT];
        if (i_cs_n && st_r != bacp_pkg::BACP_CAL) begin
            st_nxt  = bacp_pkg::BACP_CMD;
            cnt_nxt = '0;
            if (st_r == bacp_pkg::BACP_RD) begin
                data_ready_n_n_nxt = 1'b1;
            end
        end else begin
            case (st_r)
                bacp_pkg::BACP_CMD: begin
                    if (rise) begin
                        shin_nxt = {shin_r[22:0], i_sdi};
                        cnt_nxt  = cnt_r + 1'b1;
                    end
                    if (fall && cnt_r == bacp_pkg::CMD_LAST + 5'h01) begin
                            cnt_nxt = '0;
                            sel_nxt = cmd[bacp_pkg::SEL_HI:bacp_pkg::SEL_LO];
                            if (!cmd_ok(cmd)) begin
                                st_nxt = bacp_pkg::BACP_CMD;
                            end else if (cmd[bacp_pkg::RW_BIT]) begin
                                st_nxt = bacp_pkg::BACP_FET;
                            end else if (cmd[bacp_pkg::SEL_HI:
                                             bacp_pkg::SEL_LO]
                                         == bacp_pkg::SEL_RESULT) begin
                                st_nxt = bacp_pkg::BACP_CMD;
                            end else begin
                                st_nxt = bacp_pkg::BACP_WR;
                            end
                    end
                end
                bacp_pkg::BACP_WR: begin
                    if (rise) begin
                        shin_nxt = {shin_r[22:0], i_sdi};
                    end
                    if (fall) begin
                        cnt_nxt = cnt_r + 1'b1;
                        if (cnt_r == bacp_pkg::WORD_LAST) begin
                            cnt_nxt = '0;
                            st_nxt  = bacp_pkg::BACP_CMD;
                            regs_nxt[sel_r] = shin_r;
                            if (sel_r == bacp_pkg::SEL_SETUP) begin
                                regs_nxt[sel_r][bacp_pkg::TRIM_HI:
                                                bacp_pkg::TRIM_LO] =
                                    regs_r[bacp_pkg::SEL_TRIM][3:0];
                            end
                        end
                    end
                end
                bacp_pkg::BACP_FET: begin
                    shout_nxt  = regs_r[sel_r];
                    sdo_nxt    = regs_r[sel_r][bacp_pkg::WORD_W-1];
                    data_ready_n_n_nxt = 1'b0;
                    st_nxt     = bacp_pkg::BACP_RD;
                end
                bacp_pkg::BACP_RD: begin
                    if (fall) begin
                        shout_nxt = {shout_r[22:0], 1'b0};
                        sdo_nxt   = shout_r[22];
                        cnt_nxt   = cnt_r + 1'b1;
                        if (cnt_r == bacp_pkg::WORD_LAST) begin
                            cnt_nxt    = '0;
                            st_nxt     = bacp_pkg::BACP_CMD;
                            data_ready_n_n_nxt = 1'b1;
                        end
                    end
                end
                bacp_pkg::BACP_CAL: begin
                    data_ready_n_n_nxt = 1'b1;
                    if (calcnt_r == '0) begin
                        data_ready_n_n_nxt = 1'b0;
                        st_nxt     = bacp_pkg::BACP_CMD;
                        cnt_nxt    = '0;
                    end else begin
                        calcnt_nxt = calcnt_r - 1'b1;
                    end
                end
                default: st_nxt = bacp_pkg::BACP_CMD;
            endcase
        end
        // Keep the mirrored trim field in step with the trim register
        regs_nxt[bacp_pkg::SEL_SETUP][bacp_pkg::TRIM_HI:bacp_pkg::TRIM_LO] =
            regs_nxt[bacp_pkg::SEL_TRIM][3:0];
        if (wr_done && regs_nxt[bacp_pkg::SEL_SETUP][bacp_pkg::F_RUNCAL]
            && regs_nxt[bacp_pkg::SEL_SETUP][bacp_pkg::F_CALT_HI:
                                             bacp_pkg::F_CALT_LO]
               != bacp_pkg::CALT_NONE) begin
            st_nxt     = bacp_pkg::BACP_CAL;
            start_nxt  = 1'b1;
            data_ready_n_n_nxt = 1'b1;
            calcnt_nxt = cal_len(regs_nxt[bacp_pkg::SEL_SETUP]
                                 [bacp_pkg::F_CALT_HI:bacp_pkg::F_CALT_LO]);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_r     <= bacp_pkg::BACP_CMD;
            cnt_r    <= '0;
            shin_r   <= '0;
            shout_r  <= '0;
            sel_r    <= bacp_pkg::SEL_RESULT;
            sdo_r    <= 1'b0;
            data_ready_n_n_r <= 1'b1;
            sclk_d_r <= 1'b0;
            start_r  <= 1'b0;
            calcnt_r <= '0;
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= (i == int'(bacp_pkg::SEL_GAIN))
                                      ? bacp_pkg::GAIN_RST
                                      : bacp_pkg::ZERO_RST;
            end
        end else if (i_ce) begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            shin_r   <= shin_nxt;
            shout_r  <= shout_nxt;
            sel_r    <= sel_nxt;
            sdo_r    <= sdo_nxt;
            data_ready_n_n_r <= data_ready_n_n_nxt;
            sclk_d_r <= i_sclk;
            start_r  <= start_nxt;
            calcnt_r <= calcnt_nxt;
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end

    // Setup word decode, live from the register
    assign exc.outside  = setup[bacp_pkg::F_OUTSIDE];
    assign exc.rate     = setup[bacp_pkg::F_RATE_HI:bacp_pkg::F_RATE_LO];
    assign exc.pin_a_in = i_excitation_pin_a;
    assign o_excitation_pin_a    = exc.pin_a;
    assign o_excitation_pin_a_oe = exc.pin_a_oe;
    assign o_excitation_pin_b    = exc.pin_b;
    assign o_demod_phase         = exc.demod_phase;

    always_comb begin
        case (setup[bacp_pkg::F_GAIN_HI:bacp_pkg::F_GAIN_LO])
            2'h0:    o_pga_gain = 4'h1;
            2'h2:    o_pga_gain = 4'h2;
            2'h1:    o_pga_gain = 4'h4;
            default: o_pga_gain = 4'h8;
        endcase
    end

    // Trim level n means (n+1) quarters of full scale
    assign o_trim_subtract = setup[bacp_pkg::TRIM_HI];
    assign o_trim_level    = {1'b0, setup[bacp_pkg::TRIM_HI-1:
                                          bacp_pkg::TRIM_LO]} + 4'h1;
    assign o_unipolar      = setup[bacp_pkg::F_POLARITY];
    assign o_sleep         = setup[bacp_pkg::F_SLEEP];
    assign o_cal_type      = setup[bacp_pkg::F_CALT_HI:
                                   bacp_pkg::F_CALT_LO];
    assign o_filter_clear  = setup[bacp_pkg::F_FILTCLR];
    assign o_cal_busy      = (st_r == bacp_pkg::BACP_CAL);
    assign o_cal_start     = start_r;
    assign o_setup_word    = setup;
    assign o_data_ready_n  = data_ready_n_n_r;
    assign o_sdo           = sdo_r;
    assign o_sdo_oe        = (st_r == bacp_pkg::BACP_RD) & ~i_cs_n;
endmodule
`default_nettype wire

// ==== verilog/bacp_exc_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module bacp_exc_gen (
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_ce,
    bacp_exc_if.gen   exc
);
    logic [bacp_pkg::DIV_W-1:0] div_r, div_nxt;
    logic                       ph_r, ph_nxt;
    logic [bacp_pkg::DIV_W-1:0] half;

    always_comb begin
        case (exc.rate)
            bacp_pkg::RATE_8K:  half = bacp_pkg::HALF_8K;
            bacp_pkg::RATE_16K: half = bacp_pkg::HALF_16K;
            default:            half = bacp_pkg::HALF_4K;
        endcase
        div_nxt = div_r;
        ph_nxt  = ph_r;
        if (exc.rate == bacp_pkg::RATE_DC) begin
            div_nxt = '0;
            ph_nxt  = 1'b0;
        end else if (div_r >= half) begin
            div_nxt = '0;
            ph_nxt  = ~ph_r;
        end else begin
            div_nxt = div_r + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            div_r <= '0;
            ph_r  <= 1'b0;
        end else if (i_ce) begin
            div_r <= div_nxt;
            ph_r  <= ph_nxt;
        end
    end

    // Outside drive: pin a becomes an input that steers phase and pin b
    assign exc.pin_a_oe    = ~exc.outside;
    assign exc.pin_a       = ph_r;
    assign exc.pin_b       = exc.outside ? ~exc.pin_a_in : ~ph_r;
    assign exc.demod_phase = exc.outside ? exc.pin_a_in : ph_r;
endmodule
`default_nettype wire
